// ### adcc_top.v
// successive-approximation converter control with apb registers and pin control
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defs.vh"
module adcc_top (
    // clock and reset
    input  wire        sys_clk,
    input  wire        resetn,
    input  wire        clk_en,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    // clocks and trigger from outside
    input  wire        alternate_clock,
    input  wire        async_conv_clock,
    input  wire        hw_trigger_input,
    input  wire        stop_mode,
    // analog core
    output reg  [4:0]  ana_channel_ff,
    output reg         ana_sample_ff,
    output reg         ana_power_ff,
    input  wire        sar_cmp,
    // pin control
    output wire [15:0] analog_pin_disable_bit,
    output wire [15:0] pin_pullup_off,
    output wire [15:0] pin_input_off,
    input  wire [15:0] port_pin_in,
    output wire [15:0] port_read_data,
    // interrupt
    output wire        conv_irq
);
    // ------------------------------------------------------------------------
    // state encoding
    // ------------------------------------------------------------------------
    localparam ST_IDLE   = 3'b001;
    localparam ST_SAMPLE = 3'b010;
    localparam ST_APPROX = 3'b100;

    reg  [7:0]  sc1_ff;
    reg  [7:0]  sc2_ff;
    reg  [7:0]  cfg_ff;
    reg  [7:0]  cvh_ff;
    reg  [7:0]  cvl_ff;
    reg  [7:0]  rh_ff;
    reg  [7:0]  rl_ff;
    reg  [7:0]  pd2_ff;
    reg  [7:0]  pd3_ff;
    reg         hi_read_ff;
    reg         trig_armed_ff;
    reg  [2:0]  state_ff;
    reg  [5:0]  step_ff;
    reg  [11:0] sar_ff;
    reg  [11:0] bit_ff;

    wire        conv_tick;
    wire        trig_rise;
    wire        alt_lvl;
    wire        alt_rise;
    wire        ack_lvl;
    wire        ack_rise;

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function is_wr;
        input [11:0] a;
        begin
            is_wr = psel & penable & pwrite & (paddr == a);
        end
    endfunction

    function is_rd;
        input [11:0] a;
        begin
            is_rd = psel & penable & ~pwrite & (paddr == a);
        end
    endfunction

    // ------------------------------------------------------------------------
    // apb access decode
    // ------------------------------------------------------------------------
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    wire        wr_sc1  = is_wr(`ADCC_A_SC1);
    wire        cfg_wr  = is_wr(`ADCC_A_SC2) | is_wr(`ADCC_A_CFG) |
                          is_wr(`ADCC_A_CVH) | is_wr(`ADCC_A_CVL);
    wire        rd_rh   = is_rd(`ADCC_A_RH);
    wire        rd_rl   = is_rd(`ADCC_A_RL);
    wire [4:0]  new_ch  = pwdata[`ADCC_CH_W-1:0];
    wire [4:0]  chan    = sc1_ff[`ADCC_CH_W-1:0];
    wire        ch_off  = (chan == `ADCC_CH_OFF);
    wire [1:0]  mode    = cfg_ff[`ADCC_CFG_MD_HI:`ADCC_CFG_MD_LO];
    wire        mode8   = (mode == `ADCC_MODE_8);
    wire        hw_mode = sc2_ff[`ADCC_SC2_HWT];
    wire        cont    = sc1_ff[`ADCC_SC1_CONT];
    wire        cmp_en  = sc2_ff[`ADCC_SC2_CMPE];
    wire        async_sel = (cfg_ff[`ADCC_CFG_IC_HI:`ADCC_CFG_IC_LO] == `ADCC_ICLK_ASYNC);
    wire        busy    = ~state_ff[0];

    // ------------------------------------------------------------------------
    // external inputs, synchronised
    // ------------------------------------------------------------------------
    adcc_sync u_trig (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .clk_en   (clk_en),
        .async_in (hw_trigger_input),
        .level    (),
        .rise     (trig_rise)
    );

    adcc_sync u_alt (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .clk_en   (clk_en),
        .async_in (alternate_clock),
        .level    (alt_lvl),
        .rise     (alt_rise)
    );

    // the async clock keeps ticking in stop, so stop does not abort it
    adcc_sync u_ack (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .clk_en   (clk_en),
        .async_in (async_conv_clock),
        .level    (ack_lvl),
        .rise     (ack_rise)
    );

    adcc_clkdiv u_div (
        .sys_clk             (sys_clk),
        .resetn              (resetn),
        .clk_en              (clk_en),
        .run                 (busy),
        .input_clock_select  (cfg_ff[`ADCC_CFG_IC_HI:`ADCC_CFG_IC_LO]),
        .clock_divide_select (cfg_ff[`ADCC_CFG_DIV_HI:`ADCC_CFG_DIV_LO]),
        .alt_tick            (alt_rise),
        .async_tick          (ack_rise),
        .conv_tick_ff        (conv_tick)
    );

    // ------------------------------------------------------------------------
    // start, abort and result shaping
    // ------------------------------------------------------------------------
    wire sw_start = wr_sc1 & ~sc2_ff[`ADCC_SC2_HWT] &
                    (new_ch != `ADCC_CH_OFF);
    // a trigger edge while busy, or after a continuous sequence launched, is dropped
    wire hw_start = hw_mode & trig_rise & ~busy & ~ch_off & trig_armed_ff;
    wire abort    = cfg_wr | wr_sc1 | (stop_mode & ~async_sel);

    wire        done   = state_ff[2] & conv_tick & (step_ff == 6'h01);
    // the last trial bit is decided on the done tick itself, in every mode
    wire [11:0] raw    = sar_ff & ~(bit_ff & {12{~sar_cmp}});
    wire [11:0] raw_up2 = raw + 12'h002;
    wire [8:0]  raw_up1 = raw[11:3] + 9'h001;
    wire [11:0] rnd10  = {2'h0, raw_up2[11:2]};
    wire [11:0] rnd8   = {4'h0, raw_up1[8:1]};
    reg  [11:0] result;
    always @* begin
        case (mode)
            `ADCC_MODE_10: result = (raw[11:2] == 10'h3ff) ? 12'h3ff : rnd10;
            `ADCC_MODE_8:  result = (raw[11:4] == 8'hff) ? 12'h0ff : rnd8;
            default:       result = raw;
        endcase
    end
    wire [11:0] cmp_val = {cvh_ff[3:0], cvl_ff};
    wire        cmp_gte = (result >= cmp_val);
    wire        cmp_ok  = ~cmp_en |
                          (sc2_ff[`ADCC_SC2_CMPGT] ? cmp_gte : ~cmp_gte);
    wire [11:0] cmp_diff = result - cmp_val;
    wire        blocked  = hi_read_ff & ~mode8;
    wire        xfer     = done & cmp_ok & ~blocked;
    wire        restart  = done & ((cont & ~(blocked & ~cmp_ok)) |
                                   (blocked & cmp_ok) |
                                   (blocked & ~cmp_ok & cont));

    // ------------------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------------------
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff       <= ST_IDLE;
            step_ff        <= 6'h00;
            sar_ff         <= 12'h000;
            bit_ff         <= 12'h000;
            ana_sample_ff  <= 1'b0;
            ana_power_ff   <= 1'b0;
            ana_channel_ff <= 5'h00;
        end else if (clk_en) begin
            if ((abort | ch_off) & ~sw_start) begin
                state_ff      <= ST_IDLE;
                ana_sample_ff <= 1'b0;
                ana_power_ff  <= 1'b0;
            end else if (sw_start | hw_start | restart) begin
                state_ff       <= ST_SAMPLE;
                step_ff        <= `ADCC_SAMPLE_T;
                ana_sample_ff  <= 1'b1;
                ana_power_ff   <= 1'b1;
                ana_channel_ff <= sw_start ? new_ch : chan;
            end else if (done) begin
                state_ff     <= ST_IDLE;
                ana_power_ff <= 1'b0;
            end else if (conv_tick) begin
                case (state_ff)
                    ST_SAMPLE: begin
                        if (step_ff == 6'h01) begin
                            state_ff      <= ST_APPROX;
                            ana_sample_ff <= 1'b0;
                            sar_ff        <= mode8 ? 12'h800 : 12'h800;
                            bit_ff        <= 12'h800;
                            step_ff       <= mode8 ? `ADCC_APPROX_9 : `ADCC_APPROX_12;
                        end else begin
                            step_ff <= step_ff - 6'h01;
                        end
                    end
                    ST_APPROX: begin
                        // keep the trial bit when the comparator says input is above it
                        sar_ff  <= (sar_ff & ~(bit_ff & {12{~sar_cmp}})) | (bit_ff >> 1);
                        bit_ff  <= bit_ff >> 1;
                        step_ff <= step_ff - 6'h01;
                    end
                    default: state_ff <= ST_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------------
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sc1_ff        <= 8'h1f;
            sc2_ff        <= `ADCC_RST8;
            cfg_ff        <= `ADCC_RST8;
            cvh_ff        <= `ADCC_RST8;
            cvl_ff        <= `ADCC_RST8;
            rh_ff         <= `ADCC_RST8;
            rl_ff         <= `ADCC_RST8;
            pd2_ff        <= `ADCC_RST8;
            pd3_ff        <= `ADCC_RST8;
            hi_read_ff    <= 1'b0;
            trig_armed_ff <= 1'b1;
        end else if (clk_en) begin
            if (wr_sc1) begin
                sc1_ff <= {1'b0, pwdata[6:0]};
            end else if (xfer) begin
                sc1_ff[`ADCC_SC1_CONVERSION_COMPLETE_FLAG] <= 1'b1;
            end else if (rd_rl) begin
                sc1_ff[`ADCC_SC1_CONVERSION_COMPLETE_FLAG] <= 1'b0;
            end
            if (is_wr(`ADCC_A_SC2)) sc2_ff <= {1'b0, pwdata[6:4], 4'h0};
            if (is_wr(`ADCC_A_CFG)) cfg_ff <= pwdata[7:0];
            if (is_wr(`ADCC_A_CVH)) cvh_ff <= {4'h0, pwdata[3:0]};
            if (is_wr(`ADCC_A_CVL)) cvl_ff <= pwdata[7:0];
            if (is_wr(`ADCC_A_PD2)) pd2_ff <= pwdata[7:0];
            if (is_wr(`ADCC_A_PD3)) pd3_ff <= pwdata[7:0];
            if (xfer) begin
                rh_ff <= cmp_en ? {4'h0, cmp_diff[11:8]} : {4'h0, result[11:8]};
                rl_ff <= cmp_en ? cmp_diff[7:0] : result[7:0];
            end
            if (rd_rh & ~mode8) begin
                hi_read_ff <= 1'b1;
            end else if (rd_rl | is_wr(`ADCC_A_CFG)) begin
                hi_read_ff <= 1'b0;
            end
            // a continuous hardware sequence re-arms only when stopped
            if (hw_start & cont) begin
                trig_armed_ff <= 1'b0;
            end else if (abort | ~cont | ~busy & ~restart) begin
                trig_armed_ff <= 1'b1;
            end
        end
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h00000000;
        end else if (clk_en & psel & ~penable & ~pwrite) begin
            case (paddr)
                `ADCC_A_SC1: prdata <= {24'h0, sc1_ff};
                `ADCC_A_SC2: prdata <= {24'h0, busy, sc2_ff[6:0]};
                `ADCC_A_RH:  prdata <= {24'h0, rh_ff};
                `ADCC_A_RL:  prdata <= {24'h0, rl_ff};
                `ADCC_A_CVH: prdata <= {24'h0, cvh_ff};
                `ADCC_A_CVL: prdata <= {24'h0, cvl_ff};
                `ADCC_A_CFG: prdata <= {24'h0, cfg_ff};
                `ADCC_A_PD2: prdata <= {24'h0, pd2_ff};
                `ADCC_A_PD3: prdata <= {24'h0, pd3_ff};
                default:     prdata <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // pin control and interrupt
    // ------------------------------------------------------------------------
    assign analog_pin_disable_bit = {pd3_ff, pd2_ff};
    // pullup control is active high: a set disable bit turns the pin pullup off
    assign pin_pullup_off = {pd3_ff, pd2_ff};
    assign pin_input_off  = {pd3_ff, pd2_ff};
    assign port_read_data = port_pin_in & ~{pd3_ff, pd2_ff};
    assign conv_irq       = sc1_ff[`ADCC_SC1_CONVERSION_COMPLETE_FLAG] & sc1_ff[`ADCC_SC1_COMPLETE_IRQ_ENABLE];

    wire unused_ok = alt_lvl | ack_lvl;
endmodule // adcc_top
`default_nettype wire

// ### adcc_defs.vh
// register map, field positions and encodings of the conversion control block
`ifndef ADCC_DEFS_VH
`define ADCC_DEFS_VH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define ADCC_A_SC1      12'h000
`define ADCC_A_SC2      12'h004
`define ADCC_A_RH       12'h008
`define ADCC_A_RL       12'h00c
`define ADCC_A_CVH      12'h010
`define ADCC_A_CVL      12'h014
`define ADCC_A_CFG      12'h018
`define ADCC_A_PD2      12'h01c
`define ADCC_A_PD3      12'h020

// ----------------------------------------------------------------------------
// status_control_one fields
// ----------------------------------------------------------------------------
`define ADCC_SC1_CONVERSION_COMPLETE_FLAG   7
`define ADCC_SC1_COMPLETE_IRQ_ENABLE   6
`define ADCC_SC1_CONT   5
`define ADCC_CH_W       5
`define ADCC_CH_OFF     5'h1f

// ----------------------------------------------------------------------------
// status_control_two fields
// ----------------------------------------------------------------------------
`define ADCC_SC2_ACT    7
`define ADCC_SC2_HWT    6
`define ADCC_SC2_CMPE   5
`define ADCC_SC2_CMPGT  4

// ----------------------------------------------------------------------------
// config_register fields and encodings
// ----------------------------------------------------------------------------
`define ADCC_CFG_DIV_HI 6
`define ADCC_CFG_DIV_LO 5
`define ADCC_CFG_MD_HI  3
`define ADCC_CFG_MD_LO  2
`define ADCC_CFG_IC_HI  1
`define ADCC_CFG_IC_LO  0
`define ADCC_MODE_8     2'h0
`define ADCC_MODE_12    2'h1
`define ADCC_MODE_10    2'h2
`define ADCC_ICLK_BUS   2'h0
`define ADCC_ICLK_BUS2  2'h1
`define ADCC_ICLK_ALT   2'h2
`define ADCC_ICLK_ASYNC 2'h3

// ----------------------------------------------------------------------------
// reset values and conversion timing in conversion_clock ticks
// ----------------------------------------------------------------------------
`define ADCC_RST8       8'h00
`define ADCC_SAMPLE_T   6'h04
`define ADCC_STEP_W     6
`define ADCC_APPROX_12  6'h0c
`define ADCC_APPROX_9   6'h09

`endif

// ### adcc_clkdiv.v
// conversion clock source selection and post-divider, as a tick enable
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defs.vh"
module adcc_clkdiv (
    // clock and reset
    input  wire       sys_clk,
    input  wire       resetn,
    input  wire       clk_en,
    // control
    input  wire       run,
    input  wire [1:0] input_clock_select,
    input  wire [1:0] clock_divide_select,
    input  wire       alt_tick,
    input  wire       async_tick,
    // output
    output reg        conv_tick_ff
);
    reg  [2:0] div_cnt_ff;
    reg        half_ff;
    reg        src_tick;
    reg  [2:0] div_max;

    always @* begin
        case (input_clock_select)
            `ADCC_ICLK_BUS:   src_tick = 1'b1;
            `ADCC_ICLK_BUS2:  src_tick = half_ff;
            `ADCC_ICLK_ALT:   src_tick = alt_tick;
            default:          src_tick = async_tick;
        endcase
        case (clock_divide_select)
            2'h0:    div_max = 3'h0;
            2'h1:    div_max = 3'h1;
            2'h2:    div_max = 3'h3;
            default: div_max = 3'h7;
        endcase
    end

    // generator idles with no conversion running to save power
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            div_cnt_ff   <= 3'h0;
            half_ff      <= 1'b0;
            conv_tick_ff <= 1'b0;
        end else if (clk_en) begin
            half_ff      <= run & ~half_ff;
            conv_tick_ff <= 1'b0;
            if (!run) begin
                div_cnt_ff <= 3'h0;
            end else if (src_tick) begin
                if (div_cnt_ff >= div_max) begin
                    div_cnt_ff   <= 3'h0;
                    conv_tick_ff <= 1'b1;
                end else begin
                    div_cnt_ff <= div_cnt_ff + 3'h1;
                end
            end
        end
    end
endmodule // adcc_clkdiv
`default_nettype wire

// ### adcc_sync.v
// two-flop synchroniser with rising edge detect
`timescale 1ns/1ps
`default_nettype none
module adcc_sync (
    // clock and reset
    input  wire sys_clk,
    input  wire resetn,
    input  wire clk_en,
    // signal
    input  wire async_in,
    output wire level,
    output wire rise
);
    reg s1_ff;
    reg s2_ff;
    reg s3_ff;

    // only s2 and s3 feed logic; s1 may be metastable
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else if (clk_en) begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end
    assign level = s2_ff;
    assign rise  = s2_ff & ~s3_ff;
endmodule // adcc_sync
`default_nettype wire

// ### adcc_properties.sv
// concurrent checks on the ports of the conversion control block
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defs.vh"
module adcc_properties (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        resetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // analog core
    input wire logic        ana_power_ff,
    input wire logic        ana_sample_ff,
    // pins
    input wire logic [15:0] analog_pin_disable_bit,
    input wire logic [15:0] pin_pullup_off,
    input wire logic [15:0] pin_input_off,
    input wire logic [15:0] port_pin_in,
    input wire logic [15:0] port_read_data
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    wire  wr = psel && penable && pwrite;
    logic hw_sel_ff;
    // software starts are ignored while the hardware trigger is selected, so track it
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) hw_sel_ff <= 1'b0;
        else if (wr && paddr == `ADCC_A_SC2) hw_sel_ff <= pwdata[`ADCC_SC2_HWT];
    end
    chk_port_read_mask: assert property (port_read_data == (port_pin_in & ~analog_pin_disable_bit))
        else $error("port read not masked by disable bits");
    chk_pullup_follows: assert property (pin_pullup_off == analog_pin_disable_bit)
        else $error("pullup control differs from disable bits");
    chk_input_follows: assert property (pin_input_off == analog_pin_disable_bit)
        else $error("input buffer control differs from disable bits");
    chk_low_pins_write: assert property (wr && paddr == `ADCC_A_PD2
        |=> analog_pin_disable_bit[7:0] == $past(pwdata[7:0]))
        else $error("low pin disable write lost");
    chk_high_pins_write: assert property (wr && paddr == `ADCC_A_PD3
        |=> analog_pin_disable_bit[15:8] == $past(pwdata[7:0]))
        else $error("high pin disable write lost");
    chk_low_pins_read: assert property (psel && penable && !pwrite && paddr == `ADCC_A_PD2
        |-> prdata == {24'h0, analog_pin_disable_bit[7:0]})
        else $error("low pin disable readback wrong");
    chk_off_code_idle: assert property (wr && paddr == `ADCC_A_SC1 && pwdata[4:0] == `ADCC_CH_OFF
        |-> ##[1:3] !ana_power_ff)
        else $error("converter powered with channel all ones");
    chk_sw_start: assert property (wr && paddr == `ADCC_A_SC1 && pwdata[4:0] != `ADCC_CH_OFF
        && !hw_sel_ff |-> ##[1:4] ana_power_ff)
        else $error("software write did not start a conversion");
    chk_sample_powered: assert property (ana_sample_ff |-> ana_power_ff)
        else $error("sampling while converter idle");
    cov_sample: cover property (ana_sample_ff);
    cov_start: cover property ($rose(ana_power_ff));
    cov_pins: cover property (wr && paddr == `ADCC_A_PD3);
endmodule // adcc_properties
`default_nettype wire

// ### adcc_ana_model.sv
// analog core stand-in: an input held at ground
`timescale 1ns/1ps
`default_nettype none
module adcc_ana_model (
    // clock and reset
    input wire logic  sys_clk,
    input wire logic  resetn,
    // core
    input wire logic  ana_power_ff,
    output var logic  sar_cmp
);
    logic tog_ff;
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) tog_ff <= 1'b0;
        else tog_ff <= ~tog_ff;
    end
    // every trial bit rejected; outside a conversion the line wanders so nothing can lean on it
    assign sar_cmp = ana_power_ff ? 1'b0 : tog_ff;
endmodule // adcc_ana_model
`default_nettype wire

// ### adcc_top_tb_top.sv
// self-checking bench for the conversion control block
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defs.vh"
module adcc_top_tb_top;
    logic        sys_clk, resetn, psel, penable, pwrite, hw_trig, alt_clk, async_clk, stop;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd, seed;
    logic [15:0] pins;
    logic [6:0]  cfg;
    wire         pready, pslverr, sar_cmp, conv_irq, ana_sample_ff, ana_power_ff;
    wire  [31:0] prdata;
    wire  [4:0]  ana_channel_ff;
    wire  [15:0] pd, pu, pi, prd;
    int          fail_count, tests_run, i;
    adcc_top dut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .alternate_clock(alt_clk),
        .async_conv_clock(async_clk), .hw_trigger_input(hw_trig), .stop_mode(stop),
        .ana_channel_ff(ana_channel_ff), .ana_sample_ff(ana_sample_ff),
        .ana_power_ff(ana_power_ff), .sar_cmp(sar_cmp), .analog_pin_disable_bit(pd),
        .pin_pullup_off(pu), .pin_input_off(pi), .port_pin_in(pins), .port_read_data(prd),
        .conv_irq(conv_irq));
    adcc_ana_model ana (.sys_clk(sys_clk), .resetn(resetn), .ana_power_ff(ana_power_ff),
        .sar_cmp(sar_cmp));
    initial begin sys_clk = 1'b0; forever #2.5 sys_clk = ~sys_clk; end
    initial begin alt_clk = 1'b0; forever #13 alt_clk = ~alt_clk; end
    initial begin async_clk = 1'b0; forever #17 async_clk = ~async_clk; end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task print_verdict;
        if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // status polling only, the result registers stay untouched while converting
    task wait_flag;
        rd = 32'h0;
        for (i = 0; i < 600 && rd[7] !== 1'b1; i++) apb(1'b0, `ADCC_A_SC1, 32'h0);
    endtask
    initial begin
        resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
        pwdata = 32'h0; hw_trig = 1'b0; pins = 16'h0; seed = 32'h909f; stop = 1'b0;
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        rdchk(`ADCC_A_PD2, 32'h0);
        rdchk(`ADCC_A_PD3, 32'h0);
        rdchk(`ADCC_A_SC1, 32'h1f);
        rdchk(`ADCC_A_CFG, 32'h0);
        rdchk(12'h100, 32'h0);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            pins <= seed[31:16];
            apb(1'b1, `ADCC_A_PD2, {24'h0, seed[7:0]});
            apb(1'b1, `ADCC_A_PD3, {24'h0, seed[15:8]});
            rdchk(`ADCC_A_PD3, {24'h0, seed[15:8]});
            chk({16'h0, pd}, {16'h0, seed[15:0]});
            chk({16'h0, prd}, {16'h0, seed[31:16] & ~seed[15:0]});
        end
        // every source and divider once, modes 8, 12, 10 and 8 again; the grounded input gives a zero result
        for (int c = 0; c < 4; c++) begin
            cfg = {c[1:0], 1'b0, 2'(c % 3), c[1:0]};
            apb(1'b1, `ADCC_A_CFG, {25'h0, cfg});
            apb(1'b1, `ADCC_A_SC1, 32'h43);
            wait_flag;
            chk(rd, 32'hc3);
            chk({31'h0, conv_irq}, 32'h1);
            chk({27'h0, ana_channel_ff}, 32'h3);
            rdchk(`ADCC_A_RH, 32'h0);
            rdchk(`ADCC_A_RL, 32'h0);
        end
        // stop keeps an async-clocked conversion alive but aborts a bus-clocked one
        stop <= 1'b1;
        apb(1'b1, `ADCC_A_SC1, 32'h03);
        wait_flag;
        chk(rd, 32'h83);
        apb(1'b1, `ADCC_A_CFG, 32'h0);
        apb(1'b1, `ADCC_A_SC1, 32'h03);
        repeat (40) @(posedge sys_clk);
        chk({31'h0, ana_power_ff}, 32'h0);
        rdchk(`ADCC_A_SC1, 32'h03);
        stop <= 1'b0;
        apb(1'b1, `ADCC_A_SC1, 32'h1f);
        repeat (40) @(posedge sys_clk);
        chk({31'h0, ana_power_ff}, 32'h0);
        apb(1'b1, `ADCC_A_CFG, 32'h4);
        apb(1'b1, `ADCC_A_CVL, 32'h0);
        apb(1'b1, `ADCC_A_CVH, 32'h0);
        apb(1'b1, `ADCC_A_SC2, 32'h20);
        apb(1'b1, `ADCC_A_SC1, 32'h03);
        repeat (100) @(posedge sys_clk);
        rdchk(`ADCC_A_SC1, 32'h03);
        chk({31'h0, ana_power_ff}, 32'h0);
        apb(1'b1, `ADCC_A_SC2, 32'h30);
        apb(1'b1, `ADCC_A_SC1, 32'h03);
        wait_flag;
        chk(rd, 32'h83);
        apb(1'b1, `ADCC_A_SC2, 32'h0);
        apb(1'b1, `ADCC_A_SC1, 32'h03);
        apb(1'b0, `ADCC_A_RH, 32'h0);
        repeat (100) @(posedge sys_clk);
        rdchk(`ADCC_A_SC1, 32'h03);
        rdchk(`ADCC_A_SC2, 32'h80);
        rdchk(`ADCC_A_RL, 32'h0);
        wait_flag;
        chk(rd, 32'h83);
        apb(1'b1, `ADCC_A_SC1, 32'h23);
        wait_flag;
        rdchk(`ADCC_A_RL, 32'h0);
        wait_flag;
        chk(rd, 32'ha3);
        apb(1'b1, `ADCC_A_SC1, 32'h1f);
        apb(1'b1, `ADCC_A_SC2, 32'h40);
        apb(1'b1, `ADCC_A_SC1, 32'h03);
        rdchk(`ADCC_A_SC2, 32'h40);
        hw_trig <= 1'b1;
        wait_flag;
        chk(rd, 32'h83);
        print_verdict;
    end
    initial begin
        #400000;
        fail_count++;
        print_verdict;
    end
endmodule // adcc_top_tb_top
bind adcc_top adcc_properties chk_i (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .ana_power_ff(ana_power_ff), .ana_sample_ff(ana_sample_ff),
    .analog_pin_disable_bit(analog_pin_disable_bit), .pin_pullup_off(pin_pullup_off),
    .pin_input_off(pin_input_off), .port_pin_in(port_pin_in), .port_read_data(port_read_data));
`default_nettype wire
